// ==== bench/ocr_config_regs_bench.sv ====
// Bench for the OTP setup register bank: bus, loader, decode and sequencer
// Assumes ocr_config_regs with SLOT_CYCLES of 4 and a 5 ns clock
`timescale 1ns/1ps
`default_nettype none
`include "ocr_map.svh"
module ocr_config_regs_bench;
  localparam int SLOT = 4;
  localparam logic [31:0] A_CONV = {14'h0, `OCR_CONV_IDX, 2'b00};
  localparam logic [31:0] A_REGP = {14'h0, `OCR_REGP_IDX, 2'b00};
  localparam logic [31:0] A_STAT = {14'h0, `OCR_STAT_IDX, 2'b00};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, load_valid, src, seq_start, hw1, hw2;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, cap, f1, f2, en;
  logic [15:0] lidx, ldat, rnd, m_conv, m_regp;
  ocr_pkg::ocr_mv_t mv1, mv2;
  int num_errors, n_checks, n;
  int cyc = 0;

  ocr_config_regs #(.SLOT_CYCLES(SLOT)) ocr_config_regs_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .load_valid(load_valid), .config_load_source(src), .load_index(lidx), .load_data(ldat),
    .seq_start(seq_start), .hw_enable1(hw1), .hw_enable2(hw2), .buck1_cap_range(cap),
    .buck1_switch_rate(f1), .buck2_switch_rate(f2), .linreg_enable(en), .linreg1_mv(mv1),
    .linreg2_mv(mv2));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] mv_of(input int c);
    return 32'(c <= 14 ? 900 + 50 * c : 1700 + 100 * (c - 15));
  endfunction

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    logic ok;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do begin
      @(negedge hclk);
      ok = hreadyout;
      @(posedge hclk);
    end while (ok !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(negedge hclk);
      ok = hreadyout;
      r = hrdata;
      @(posedge hclk);
    end while (ok !== 1'b1);
  endtask

  task automatic load(input logic [15:0] i, input logic [15:0] d);
    @(posedge hclk);
    load_valid <= 1'b1;
    lidx <= i;
    ldat <= d;
    src <= d[15];
    @(posedge hclk);
    load_valid <= 1'b0;
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, load_valid, src, seq_start, hw1, hw2} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = '0;
    lidx = '0;
    ldat = '0;
    rnd = 16'hDC35;
    num_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, A_CONV, 32'h0, rd);
    chk(rd, 32'h0);
    chk({20'h0, mv1}, 32'd900);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b0, A_REGP + 32'h8, 32'h0, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      m_conv = {10'h0, rnd[5:0]};
      load(`OCR_CONV_IDX, rnd);
      load(16'h7815, ~rnd);
      @(negedge hclk);
      chk({26'h0, cap, f2, f1}, {16'h0, m_conv});
      bus(1'b1, A_CONV, {16'h0, ~rnd}, rd);
      bus(1'b0, A_CONV, 32'h0, rd);
      chk(rd, {16'h0, m_conv});
    end
    for (int c = 0; c < 32; c++) begin
      m_regp = {3'h0, 5'(c), 3'h0, 5'(31 - c)};
      bus(1'b1, A_REGP, {16'h0, m_regp}, rd);
      @(posedge hclk);
      @(negedge hclk);
      chk({20'h0, mv2}, mv_of(c));
      chk({20'h0, mv1}, mv_of(31 - c));
      chk({30'h0, en}, 32'h0);
      bus(1'b0, A_REGP, 32'h0, rd);
      chk(rd, {16'h0, m_regp});
    end
    bus(1'b1, A_REGP, 32'hE07F, rd);
    @(posedge hclk);
    seq_start <= 1'b1;
    @(posedge hclk);
    seq_start <= 1'b0;
    for (n = 1; n < 40; n++) begin
      @(posedge hclk);
      @(negedge hclk);
      if (en[0] === 1'b1) break;
    end
    chk(32'(n), 32'((3 - 1) * SLOT + 1));
    chk({31'h0, en[1]}, 32'h0);
    for (int k = 1; k < 5; k++) begin
      bus(1'b1, A_REGP, k < 4 ? 32'hE0DF : 32'h001F, rd);
      hw1 <= k[0] | k[2];
      hw2 <= k[1] | k[2];
      repeat (6) @(posedge hclk);
      @(negedge hclk);
      chk({30'h0, en}, k < 4 ? 32'(k) : 32'h0);
    end
    bus(1'b0, A_STAT, 32'h0, rd);
    chk(rd, {25'h0, ~rnd[15], 1'b1, `OCR_SLOT_LAST, 2'b00});
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, A_CONV, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, A_STAT, 32'h0, rd);
    chk(rd, 32'h0);
    chk({20'h0, mv2}, 32'd900);
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== rtl/ocr_config_regs.sv ====
// OTP setup registers for two converters and two linear regulators, AHB-Lite slave
// Assumes the config loader and seq_start share hclk; hardware enables are async pins
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ocr_map.svh"
module ocr_config_regs #(
  parameter int SLOT_CYCLES = (`OCR_SLOT_NS + `OCR_CLK_NS - 1) / `OCR_CLK_NS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic load_valid,
  input wire logic config_load_source,
  input wire logic [15:0] load_index,
  input wire logic [15:0] load_data,
  input wire logic seq_start,
  input wire logic hw_enable1,
  input wire logic hw_enable2,
  output logic [1:0] buck1_cap_range,
  output logic [1:0] buck1_switch_rate,
  output logic [1:0] buck2_switch_rate,
  output logic [1:0] linreg_enable,
  output ocr_pkg::ocr_mv_t linreg1_mv,
  output ocr_pkg::ocr_mv_t linreg2_mv
);
  import ocr_pkg::*;

  // Register bank state, read by the bus decode
  logic [15:0] conv_ff, nxt_conv;
  logic [15:0] regp_ff, nxt_regp;
  logic src_ff, nxt_src;
  logic [15:0] status;
  logic sw_wr;

  // Bus state
  logic wr_pend_ff, nxt_wr_pend;
  logic rd_pend_ff, nxt_rd_pend;
  logic [15:0] idx_ff, nxt_idx;
  logic addr_ok_ff, nxt_addr_ok;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic take;

  always_comb begin
    take = hsel && hready && htrans[1];
    nxt_wr_pend = take && hwrite;
    nxt_rd_pend = take && !hwrite;
    nxt_idx = take ? haddr[17:2] : idx_ff;
    nxt_addr_ok = take ? (haddr[31:18] == 14'h0000 && haddr[1:0] == 2'h0) : addr_ok_ff;
    nxt_hrdata = hrdata_ff;
    if (rd_pend_ff) begin
      nxt_hrdata = 32'h0000_0000;
      if (addr_ok_ff && idx_ff == `OCR_CONV_IDX) begin
        nxt_hrdata[15:0] = conv_ff;
      end else if (addr_ok_ff && idx_ff == `OCR_REGP_IDX) begin
        nxt_hrdata[15:0] = regp_ff;
      end else if (addr_ok_ff && idx_ff == `OCR_STAT_IDX) begin
        nxt_hrdata[15:0] = status;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      idx_ff <= 16'h0000;
      addr_ok_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      rd_pend_ff <= nxt_rd_pend;
      idx_ff <= nxt_idx;
      addr_ok_ff <= nxt_addr_ok;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // One wait state on reads so read data comes from a flop
  assign hreadyout = !rd_pend_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;

  // Register bank
  always_comb begin
    sw_wr = wr_pend_ff && addr_ok_ff;
    nxt_conv = conv_ff;
    nxt_regp = regp_ff;
    nxt_src = src_ff;
    if (sw_wr && idx_ff == `OCR_REGP_IDX) begin
      nxt_regp = hwdata[15:0];
    end
    if (load_valid) begin
      nxt_src = config_load_source;
      if (load_index == `OCR_CONV_IDX) begin
        nxt_conv = load_data & `OCR_CONV_MASK;
      end
      if (load_index == `OCR_REGP_IDX) begin
        nxt_regp = load_data;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_ff <= `OCR_REG_RESET;
      regp_ff <= `OCR_REG_RESET;
      src_ff <= 1'b0;
    end else begin
      conv_ff <= nxt_conv;
      regp_ff <= nxt_regp;
      src_ff <= nxt_src;
    end
  end

  assign buck1_cap_range = conv_ff[`OCR_B1CAP];
  assign buck2_switch_rate = conv_ff[`OCR_B2FREQ];
  assign buck1_switch_rate = conv_ff[`OCR_B1FREQ];

  // Hardware enable synchronisers
  logic [1:0] hw1_sync_ff, nxt_hw1_sync;
  logic [1:0] hw2_sync_ff, nxt_hw2_sync;

  always_comb begin
    nxt_hw1_sync = {hw1_sync_ff[0], hw_enable1};
    nxt_hw2_sync = {hw2_sync_ff[0], hw_enable2};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hw1_sync_ff <= 2'h0;
      hw2_sync_ff <= 2'h0;
    end else begin
      hw1_sync_ff <= nxt_hw1_sync;
      hw2_sync_ff <= nxt_hw2_sync;
    end
  end

  // Startup timeslot sequencer
  ocr_seq_t seq_ff, nxt_seq;
  ocr_slot_t slot_ff, nxt_slot;
  logic [15:0] cnt_ff, nxt_cnt;

  always_comb begin
    nxt_seq = seq_ff;
    nxt_slot = slot_ff;
    nxt_cnt = cnt_ff;
    unique case (seq_ff)
      SEQ_IDLE: begin
        if (seq_start) begin
          nxt_seq = SEQ_RUN;
          nxt_slot = `OCR_SLOT_FIRST;
          nxt_cnt = 16'h0000;
        end
      end
      SEQ_RUN: begin
        if (cnt_ff == 16'(SLOT_CYCLES - 1)) begin
          nxt_cnt = 16'h0000;
          if (slot_ff == `OCR_SLOT_LAST) begin
            nxt_seq = SEQ_DONE;
          end else begin
            nxt_slot = slot_ff + `OCR_SLOT_FIRST;
          end
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      SEQ_DONE: begin
        nxt_seq = SEQ_DONE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_ff <= SEQ_IDLE;
      slot_ff <= `OCR_SLOT_OFF;
      cnt_ff <= 16'h0000;
    end else begin
      seq_ff <= nxt_seq;
      slot_ff <= nxt_slot;
      cnt_ff <= nxt_cnt;
    end
  end

  // Per-regulator enable and voltage decode
  ocr_slot_t code_slot [2];
  ocr_volt_t code_volt [2];
  logic [1:0] en_ff, nxt_en;
  ocr_mv_t mv_ff [2];
  ocr_mv_t nxt_mv [2];

  assign code_slot[0] = regp_ff[`OCR_L1SLOT];
  assign code_slot[1] = regp_ff[`OCR_L2SLOT];
  assign code_volt[0] = regp_ff[`OCR_L1VOLT];
  assign code_volt[1] = regp_ff[`OCR_L2VOLT];

  for (genvar g = 0; g < 2; g++) begin : g_reg
    always_comb begin
      unique case (code_slot[g])
        `OCR_SLOT_OFF: nxt_en[g] = 1'b0;
        `OCR_SLOT_HW1: nxt_en[g] = hw1_sync_ff[1];
        `OCR_SLOT_HW2: nxt_en[g] = hw2_sync_ff[1];
        default: nxt_en[g] = seq_ff != SEQ_IDLE && slot_ff >= code_slot[g];
      endcase
      if (code_volt[g] <= `OCR_CODE_LO_MAX) begin
        nxt_mv[g] = `OCR_MV_BASE_LO + 12'(code_volt[g]) * `OCR_MV_STEP_LO;
      end else begin
        nxt_mv[g] = `OCR_MV_BASE_HI + 12'(code_volt[g] - `OCR_CODE_HI_MIN) * `OCR_MV_STEP_HI;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        en_ff[g] <= 1'b0;
        mv_ff[g] <= `OCR_MV_BASE_LO;
      end else begin
        en_ff[g] <= nxt_en[g];
        mv_ff[g] <= nxt_mv[g];
      end
    end

    sequence s_hw1_held;
      (code_slot[g] == `OCR_SLOT_HW1 && hw_enable1) [*4];
    endsequence
    sequence s_slot_reached;
      code_slot[g] >= `OCR_SLOT_FIRST && code_slot[g] <= `OCR_SLOT_LAST && seq_ff != SEQ_IDLE
        && slot_ff == code_slot[g];
    endsequence

    chk_off_stays_low: assert property (@(posedge hclk) disable iff (!hresetn)
      code_slot[g] == `OCR_SLOT_OFF |=> !en_ff[g]) else $error("enable on for slot code zero");
    chk_hw1_follows: assert property (@(posedge hclk) disable iff (!hresetn)
      s_hw1_held |-> en_ff[g]) else $error("enable not following hardware enable 1");
    chk_slot_start: assert property (@(posedge hclk) disable iff (!hresetn)
      s_slot_reached ##1 code_slot[g] == $past(code_slot[g]) |-> en_ff[g]) else $error("slot enable late");
    chk_volt_low: assert property (@(posedge hclk) disable iff (!hresetn)
      code_volt[g] <= 5'h0E |=> mv_ff[g] == 12'd900 + 12'd50 * 12'($past(code_volt[g])))
      else $error("low range voltage wrong");
    chk_volt_high: assert property (@(posedge hclk) disable iff (!hresetn)
      code_volt[g] >= 5'h0F |=> mv_ff[g] == 12'd1700 + 12'd100 * 12'($past(code_volt[g]) - 5'h0F))
      else $error("high range voltage wrong");
  end

  assign linreg_enable = en_ff;
  assign linreg1_mv = mv_ff[0];
  assign linreg2_mv = mv_ff[1];
  assign status = {9'h000, src_ff, seq_ff == SEQ_DONE, slot_ff, en_ff};

  chk_conv_sw_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    sw_wr && idx_ff == `OCR_CONV_IDX && !load_valid |=> $stable(conv_ff)) else $error("software changed converter setup");
  chk_conv_load_only: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(conv_ff) |-> $past(load_valid)) else $error("converter setup changed without load");
  chk_cap_load: assert property (@(posedge hclk) disable iff (!hresetn)
    load_valid && load_index == `OCR_CONV_IDX |=> buck1_cap_range == $past(load_data[`OCR_B1CAP]))
    else $error("capacitor code not loaded");
  chk_freq2_load: assert property (@(posedge hclk) disable iff (!hresetn)
    load_valid && load_index == `OCR_CONV_IDX |=> buck2_switch_rate == $past(load_data[`OCR_B2FREQ]))
    else $error("converter 2 rate not loaded");
  chk_freq1_load: assert property (@(posedge hclk) disable iff (!hresetn)
    load_valid && load_index == `OCR_CONV_IDX |=> buck1_switch_rate == $past(load_data[`OCR_B1FREQ]))
    else $error("converter 1 rate not loaded");
endmodule
`default_nettype wire

// ==== rtl/ocr_map.svh ====
// Address indices, field positions, reset values and timing for the OTP setup registers
// Assumes one 200 MHz clock; byte address is four times the index
`ifndef OCR_MAP_SVH
`define OCR_MAP_SVH
`define OCR_CONV_IDX 16'h7813
`define OCR_REGP_IDX 16'h7814
`define OCR_STAT_IDX 16'h7820
`define OCR_REG_RESET 16'h0000
`define OCR_CONV_MASK 16'h003F
`define OCR_B1CAP 5:4
`define OCR_B2FREQ 3:2
`define OCR_B1FREQ 1:0
`define OCR_L2SLOT 15:13
`define OCR_L2VOLT 12:8
`define OCR_L1SLOT 7:5
`define OCR_L1VOLT 4:0
`define OCR_SLOT_OFF 3'h0
`define OCR_SLOT_FIRST 3'h1
`define OCR_SLOT_LAST 3'h5
`define OCR_SLOT_HW1 3'h6
`define OCR_SLOT_HW2 3'h7
`define OCR_SLOT_NS 1000
`define OCR_CLK_NS 5
`define OCR_MV_BASE_LO 12'h384
`define OCR_MV_STEP_LO 12'h032
`define OCR_MV_BASE_HI 12'h6A4
`define OCR_MV_STEP_HI 12'h064
`define OCR_CODE_LO_MAX 5'h0E
`define OCR_CODE_HI_MIN 5'h0F
`endif

// ==== rtl/ocr_pkg.sv ====
// Types shared by the OTP setup register bank
// Assumes ocr_map.svh for all numeric constants
package ocr_pkg;
  typedef logic [2:0] ocr_slot_t;
  typedef logic [4:0] ocr_volt_t;
  typedef logic [11:0] ocr_mv_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} ocr_seq_t;
endpackage
